// *** bench/testbench.sv ***
// Self-checking bench: APB register checks, then digitiser lines through
// the filter and gain path. Assumes the design carries its own assertions.
`include "vgfc_cfg.svh"
`default_nettype none
module testbench
  import vgfc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, lastErr;
  logic [7:0]  lumaPin, chromaPin, lumaOut, chromaOut;
  logic        sampleValidPin, lineResetPin, chromaIsCr, outValid, outActive;
  logic        fieldOddPin = 1'b0;
  logic        go = 1'b0;
  logic        pat = 1'b0;
  logic        chk = 1'b0;
  logic        busy, cOn, seen, lastCr, eFirst;
  logic [7:0]  yA = 8'h00;
  logic [7:0]  yB = 8'h00;
  logic [7:0]  cVal = 8'h80;
  logic [7:0]  eY0, eY1, eCb, eCr, gl, gu, gv;
  logic [7:0]  ctl [2];
  logic [9:0]  hd;
  int          nAct;
  int          failCount = 0;
  int          testsRun = 0;

  // Free-running 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  vgfc_top dut_u
  (
    .clk, .rst_b, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lumaPin, .chromaPin, .sampleValidPin,
    .fieldOddPin, .lineResetPin, .lumaOut, .chromaOut, .chromaIsCr,
    .outValid, .outActive
  );

  vgfc_digitiser front_u
  (
    .clk, .go, .pat, .yA, .yB, .cVal, .len(8'h28), .lumaPin, .chromaPin,
    .sampleValidPin, .lineResetPin, .busy
  );

  task automatic reportAndStop();
    $display("tests=%0d mismatches=%0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : reportAndStop

  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpReg

  task automatic cmpPix(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpPix

  // Luma product over unity 216, clipped high instead of wrapping
  function automatic logic [7:0] expY(input int y, input vgfc_gain_t g);
    int p;
    p = y * int'(g) / 216;
    return (p > 255) ? 8'hFF : 8'(p);
  endfunction : expY

  // Chroma product of a positive offset-binary sample, clipped at +127
  function automatic logic [7:0] expC(input logic [7:0] c, input vgfc_gain_t g, input int u);
    int p;
    p = (int'(c) - 128) * int'(g) / u;
    return (p > 127) ? 8'h7F : 8'(p);
  endfunction : expC

  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 40)
    begin
      failCount++;
      reportAndStop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic err);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    cmpReg(r, e);
    cmpReg({31'h0, lastErr}, {31'h0, err});
  endtask : rdChk

  // Write every setting and keep the bench's own copy for expectations
  task automatic setup(input logic [7:0] e, o, l, u, v, input logic [9:0] h);
    ctl[0] = e;
    ctl[1] = o;
    gl = l;
    gu = u;
    gv = v;
    hd = h;
    wr(`VGFC_EVEN_CTRL_OFF, {24'h00_0000, e});
    wr(`VGFC_ODD_CTRL_OFF, {24'h00_0000, o});
    wr(`VGFC_LUMA_LOW_OFF, {24'h00_0000, l});
    wr(`VGFC_U_LOW_OFF, {24'h00_0000, u});
    wr(`VGFC_V_LOW_OFF, {24'h00_0000, v});
    wr(`VGFC_HORIZONTAL_DELAY_OFF, {22'h00_0000, h});
  endtask : setup

  // Work out the expected outputs, then stream one line
  task automatic runLine(input logic odd, p, input logic [7:0] a, b, c);
    logic [7:0] k;
    int x, y, n;
    k = ctl[odd];
    x = a;
    y = p ? b : a;
    if (p && !k[7] && !k[6])
    begin
      x = (x + y) / 2;
      y = x;
    end
    else if (p && !k[5])
    begin
      x = (3 * a + b) / 4;
      y = (a + 3 * b) / 4;
    end
    eY0 = expY(x, {k[2], gl});
    eY1 = expY(y, {k[2], gl});
    eCb = k[6] ? expC(c, {k[1], gu}, 254) : 8'h00;
    eCr = k[6] ? expC(c, {k[0], gv}, 180) : 8'h00;
    eFirst = hd[0] ^ k[4];
    cOn = !p;
    seen = 1'b0;
    nAct = 0;
    fieldOddPin <= odd;
    pat <= p;
    yA <= a;
    yB <= b;
    cVal <= c;
    repeat (4) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    chk <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 200);
    chk <= 1'b0;
    repeat (10) @(posedge clk);
    cmpReg({31'h0, nAct > 20}, 32'h0000_0001);
    $display("test line done: ctrl=%h pattern=%b", k, p);
    if (n >= 200)
    begin
      failCount++;
      reportAndStop();
    end
  endtask : runLine

  // Check every active output sample while a line streams
  always @(posedge clk)
  begin
    if (chk && outValid === 1'b1 && outActive === 1'b1)
    begin
      nAct++;
      cmpPix(lumaOut, (lumaOut === eY1) ? eY1 : eY0);
      if (cOn)
        cmpPix(chromaOut, (chromaIsCr === 1'b1) ? eCr : eCb);
      cmpPix({7'h0, chromaIsCr}, {7'h0, seen ? ~lastCr : eFirst});
      seen = 1'b1;
      lastCr = chromaIsCr;
    end
  end

  // Reset, register checks, then lines in each mode
  initial
  begin
    logic [31:0] r;
    logic [7:0]  v;
    logic [7:0]  adr [5];
    logic [7:0]  mode [5];
    adr = '{`VGFC_EVEN_CTRL_OFF, `VGFC_LUMA_LOW_OFF, `VGFC_U_LOW_OFF,
            `VGFC_V_LOW_OFF, `VGFC_ODD_CTRL_OFF};
    mode = '{8'h00, 8'h20, 8'h80, 8'hA0, 8'h40};
    r = $urandom(32'h0000_1c32);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdChk(`VGFC_EVEN_CTRL_OFF, 32'h0000_0020, 1'b0);
    rdChk(`VGFC_ODD_CTRL_OFF, 32'h0000_0020, 1'b0);
    rdChk(`VGFC_LUMA_LOW_OFF, 32'h0000_00D8, 1'b0);
    rdChk(`VGFC_U_LOW_OFF, 32'h0000_00FE, 1'b0);
    rdChk(`VGFC_V_LOW_OFF, 32'h0000_00B4, 1'b0);
    rdChk(8'h40, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      v = 8'($urandom) & 8'hF7;
      wr(adr[i % 5], {24'h00_0000, v});
      rdChk(adr[i % 5], {24'h00_0000, v}, 1'b0);
    end
    $display("test registers done");
    // Flat random monochrome luma on composite input, notch kept bypassed;
    // the chroma pins are ignored
    v = 8'($urandom);
    setup(8'hA0, 8'h20, 8'hD8, 8'hFE, 8'hB4, 10'h004);
    runLine(1'b0, 1'b0, v, 8'h00, 8'hC0);
    // Y/C, luma and V gains past full scale, odd delay with inverted order
    setup(8'h75, 8'h20, 8'hFF, 8'hFE, 8'hB4, 10'h005);
    runLine(1'b0, 1'b0, 8'hF0, 8'h00, 8'hC0);
    // Odd field copy; U top bit raised by read-modify-write, V gain zero
    setup(8'h20, 8'h74, 8'hD8, 8'h80, 8'h00, 10'h004);
    apb(1'b0, `VGFC_ODD_CTRL_OFF, 32'h0000_0000, r);
    wr(`VGFC_ODD_CTRL_OFF, r | 32'h0000_0002);
    ctl[1] = r[7:0] | 8'h02;
    runLine(1'b1, 1'b0, 8'h40, 8'h00, 8'hC0);
    // Filter modes on a two-level luma pattern, chroma gains at default ratio
    for (int i = 0; i < 5; i++)
    begin
      setup(mode[i], 8'h20, 8'hD8, 8'hFE, 8'hB4, 10'h004);
      runLine(1'b0, 1'b1, 8'h40, 8'h80, 8'h80);
    end
    reportAndStop();
  end
endmodule : testbench
`default_nettype wire

// *** bench/vgfc_digitiser.sv ***
// Digitiser front-end model: streams one line of luma and chroma samples.
// Assumes the bench pulses go for one clock and waits for busy to fall.
`default_nettype none
module vgfc_digitiser
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       pat,
  input  wire logic [7:0] yA,
  input  wire logic [7:0] yB,
  input  wire logic [7:0] cVal,
  input  wire logic [7:0] len,
  output logic      [7:0] lumaPin,
  output logic      [7:0] chromaPin,
  output logic            sampleValidPin,
  output logic            lineResetPin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] k = 8'h00;
  logic       send;
  // One idle slot in eight on flat lines; a pattern must stay unbroken
  assign send = busy && !go && k >= 8'h02 && k < len && !(k[2:0] == 3'h7 && !pat);
  initial
  begin
    lumaPin = 8'h00;
    chromaPin = 8'h00;
    sampleValidPin = 1'b0;
    lineResetPin = 1'b0;
    busy = 1'b0;
  end
  // Line reset for two clocks, then samples; idle pins flip every clock
  // so that stale data can never pass for a fresh sample
  always @(posedge clk)
  begin
    k <= go ? 8'h00 : k + 8'h01;
    busy <= go || (busy && k < len);
    lineResetPin <= go || (busy && k == 8'h00);
    sampleValidPin <= send;
    lumaPin <= send ? ((pat && k[1]) ? yB : yA) : ~lumaPin;
    chromaPin <= send ? cVal : ~chromaPin;
  end
endmodule : vgfc_digitiser
`default_nettype wire

// *** design/vgfc_cfg.svh ***
// Offsets, field positions, reset values and gain constants of the
// video gain and filter control block.
// Assumes byte addressing on an APB bus with 32-bit data words.
`ifndef VGFC_CFG_SVH
`define VGFC_CFG_SVH

// Register byte offsets
`define VGFC_EVEN_CTRL_OFF  8'h2C
`define VGFC_LUMA_LOW_OFF   8'h30
`define VGFC_U_LOW_OFF      8'h34
`define VGFC_V_LOW_OFF      8'h38
`define VGFC_ODD_CTRL_OFF   8'hAC
`define VGFC_HORIZONTAL_DELAY_OFF     8'hF0
`define VGFC_STATUS_OFF     8'hF4

// Reset values
`define VGFC_CTRL_RST       8'h20
`define VGFC_LUMA_LOW_RST   8'hD8
`define VGFC_U_LOW_RST      8'hFE
`define VGFC_V_LOW_RST      8'hB4
`define VGFC_HORIZONTAL_DELAY_RST     10'h078

// Field control bit positions
`define VGFC_NOTCH_BIT      7
`define VGFC_COMP_BIT       6
`define VGFC_DECIM_BIT      5
`define VGFC_ORDER_BIT      4
`define VGFC_LGAIN_BIT      2
`define VGFC_UGAIN_BIT      1
`define VGFC_VGAIN_BIT      0

// Gain values that give unity
`define VGFC_LUMA_UNITY     9'h0D8
`define VGFC_U_UNITY        9'h0FE
`define VGFC_V_UNITY        9'h0B4

// Offset-binary to two's complement flip for chroma samples
`define VGFC_CHROMA_MID     8'h80

`endif

// *** design/vgfc_gain_clip.sv ***
// Multiplies one sample by a 9-bit gain, divides by the unity value
// and clips to the 8-bit output range.
// Assumes the caller registers the result; this module is purely combinational.
`default_nettype none

module vgfc_gain_clip
  import vgfc_pkg::*;
#(
  parameter vgfc_gain_t UNITY      = 9'h0D8,
  parameter bit         SIGNED_OUT = 1'b0
)
(
  input  wire logic signed [9:0] sample,
  input  wire vgfc_gain_t        gain,
  output logic             [7:0] result
);

  logic signed [19:0] product;
  logic signed [19:0] quot;

  // Gain of value/UNITY; division truncates toward zero
  assign product = sample * $signed({1'b0, gain});
  assign quot    = product / $signed({11'h000, UNITY});

  // Saturate instead of wrapping so overdriven pixels stay at the rail
  always_comb
  begin
    if (SIGNED_OUT)
    begin
      if (quot > 20'sh0_007F)
        result = 8'h7F;
      else if (quot < -20'sh0_0080)
        result = 8'h80;
      else
        result = quot[7:0];
    end
    else
    begin
      if (quot > 20'sh0_00FF)
        result = 8'hFF;
      else if (quot < 20'sh0_0000)
        result = 8'h00;
      else
        result = quot[7:0];
    end
  end

endmodule : vgfc_gain_clip

`default_nettype wire

// *** design/vgfc_pkg.sv ***
// Types shared by the video gain and filter control block.
// Assumes vgfc_cfg.svh holds the numeric constants.
`default_nettype none

package vgfc_pkg;

  typedef logic [7:0] vgfc_byte_t;
  typedef logic [8:0] vgfc_gain_t;

  // Register access phase of the APB slave
  typedef enum logic [0:0]
  {
    VGFC_IDLE = 1'b0,
    VGFC_DONE = 1'b1
  } vgfc_apb_t;

endpackage : vgfc_pkg

`default_nettype wire

// *** design/vgfc_top.sv ***
// Field control, gain registers and the luma/chroma filter and gain path
// of the video decoder, with an APB register slave.
// Assumes digitiser pins arrive asynchronously to clk and are synchronised here.
//
// The implementer's own choice: the APB register port.
`include "vgfc_cfg.svh"
`default_nettype none

// How it works
// - Bit 7 set bypasses the luma notch.
// - Bit 6: composite gates C ADC; Y/C bypasses notch.
// - Bit 5 clear enables luma decimation filter.
// - Bit 4 inverts Cb/Cr order of first pixel.
// - Even/odd control copies, both reset 0x20.
// - Luma gain is bit 2 plus low byte.
// - Luma scaled by gain/216, low byte resets 0xD8.
// - U gain is bit 1 plus low byte.
// - U scaled by gain/254, low byte resets 0xFE.
// - V gain is bit 0 plus low byte.
// - V scaled by gain/180, low byte resets 0xB4.
// - Horizontal delay counts pixels from line reset fall.
module vgfc_top
  import vgfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  lumaPin,
  input  wire logic [7:0]  chromaPin,
  input  wire logic        sampleValidPin,
  input  wire logic        fieldOddPin,
  input  wire logic        lineResetPin,
  output logic      [7:0]  lumaOut,
  output logic      [7:0]  chromaOut,
  output logic             chromaIsCr,
  output logic             outValid,
  output logic             outActive
);

  vgfc_apb_t         apbState_r;
  vgfc_byte_t        evenCtrl_r;
  vgfc_byte_t        oddCtrl_r;
  vgfc_byte_t        lumaLow_r;
  vgfc_byte_t        uLow_r;
  vgfc_byte_t        vLow_r;
  logic        [9:0] horizontal_delay_r;
  logic       [31:0] rdWord;
  logic        [7:0] ySync1_r, ySync2_r, cSync1_r, cSync2_r;
  logic              vSync1_r, vSync2_r, fSync1_r, fSync2_r;
  logic              hSync1_r, hSync2_r, hSync3_r;
  logic              lineFall;
  logic        [9:0] pixCount_r;
  vgfc_byte_t        ctrlSel;
  logic              notchOn, decimOn, ycMode;
  vgfc_gain_t        lumaGain, uGain, vGain;
  logic        [7:0] yD0_r, yD1_r, yD2_r, cD0_r, cD1_r;
  logic              validB_r, phaseB_r, activeB_r;
  logic       [10:0] bandPass;
  logic        [7:0] lumaN_r, lumaN1_r, lumaN2_r, lumaD_r;
  logic signed [9:0] chromaC_r, chromaD_r;
  logic              validC_r, phaseC_r, activeC_r;
  logic              validD_r, phaseD_r, activeD_r;
  logic        [7:0] lumaScaled, uScaled, vScaled;
  logic       [17:0] lumaProdChk;

  // Averages two unsigned samples; shared by the notch and decimation filters
  function automatic logic [7:0] avg2(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8:1];
  endfunction : avg2

  // Address decode for the error answer; the write strobe decodes paddr in its own case
  function automatic logic isMapped(input logic [7:0] addr);
    return (addr == `VGFC_EVEN_CTRL_OFF) || (addr == `VGFC_ODD_CTRL_OFF) ||
           (addr == `VGFC_LUMA_LOW_OFF) || (addr == `VGFC_U_LOW_OFF) ||
           (addr == `VGFC_V_LOW_OFF) || (addr == `VGFC_HORIZONTAL_DELAY_OFF) ||
           (addr == `VGFC_STATUS_OFF);
  endfunction : isMapped

  // Read multiplexer; narrow registers sit in the low bits
  always_comb
  begin
    case (paddr)
      `VGFC_EVEN_CTRL_OFF: rdWord = {24'h00_0000, evenCtrl_r};
      `VGFC_ODD_CTRL_OFF:  rdWord = {24'h00_0000, oddCtrl_r};
      `VGFC_LUMA_LOW_OFF:  rdWord = {24'h00_0000, lumaLow_r};
      `VGFC_U_LOW_OFF:     rdWord = {24'h00_0000, uLow_r};
      `VGFC_V_LOW_OFF:     rdWord = {24'h00_0000, vLow_r};
      `VGFC_HORIZONTAL_DELAY_OFF:    rdWord = {22'h00_0000, horizontal_delay_r};
      `VGFC_STATUS_OFF:    rdWord = {6'h00, pixCount_r, 12'h000, notchOn, ycMode,
                                     activeB_r, fSync2_r};
      default:             rdWord = 32'h0000_0000;
    endcase
  end

  // APB handshake: one wait state, read data loaded on the same edge that pready rises
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      apbState_r <= VGFC_IDLE;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (apbState_r)
        VGFC_IDLE:
        begin
          if (psel && penable)
          begin
            apbState_r <= VGFC_DONE;
            pready     <= 1'b1;
            pslverr    <= !isMapped(paddr);
            prdata     <= pwrite ? 32'h0000_0000 : rdWord;
          end
        end
        VGFC_DONE:
        begin
          apbState_r <= VGFC_IDLE;
          pready     <= 1'b0;
          pslverr    <= 1'b0;
        end
        default:
        begin
          apbState_r <= VGFC_IDLE;
          pready     <= 1'b0;
        end
      endcase
    end
  end

  // Writes commit on the edge that completes the transfer; bit 3 is kept as written
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      evenCtrl_r <= `VGFC_CTRL_RST;
      oddCtrl_r  <= `VGFC_CTRL_RST;
      lumaLow_r  <= `VGFC_LUMA_LOW_RST;
      uLow_r     <= `VGFC_U_LOW_RST;
      vLow_r     <= `VGFC_V_LOW_RST;
      horizontal_delay_r   <= `VGFC_HORIZONTAL_DELAY_RST;
    end
    else if (ce && apbState_r == VGFC_DONE && psel && penable && pwrite)
    begin
      case (paddr)
        `VGFC_EVEN_CTRL_OFF: evenCtrl_r <= pwdata[7:0];
        `VGFC_ODD_CTRL_OFF:  oddCtrl_r  <= pwdata[7:0];
        `VGFC_LUMA_LOW_OFF:  lumaLow_r  <= pwdata[7:0];
        `VGFC_U_LOW_OFF:     uLow_r     <= pwdata[7:0];
        `VGFC_V_LOW_OFF:     vLow_r     <= pwdata[7:0];
        `VGFC_HORIZONTAL_DELAY_OFF:    horizontal_delay_r   <= pwdata[9:0];
        default:             horizontal_delay_r   <= horizontal_delay_r;
      endcase
    end
  end

  // Two-flop synchronisers for the digitiser pins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ySync1_r <= 8'h00;
      ySync2_r <= 8'h00;
      cSync1_r <= 8'h00;
      cSync2_r <= 8'h00;
      vSync1_r <= 1'b0;
      vSync2_r <= 1'b0;
      fSync1_r <= 1'b0;
      fSync2_r <= 1'b0;
      hSync1_r <= 1'b0;
      hSync2_r <= 1'b0;
      hSync3_r <= 1'b0;
    end
    else if (ce)
    begin
      ySync1_r <= lumaPin;
      ySync2_r <= ySync1_r;
      cSync1_r <= chromaPin;
      cSync2_r <= cSync1_r;
      vSync1_r <= sampleValidPin;
      vSync2_r <= vSync1_r;
      fSync1_r <= fieldOddPin;
      fSync2_r <= fSync1_r;
      hSync1_r <= lineResetPin;
      hSync2_r <= hSync1_r;
      hSync3_r <= hSync2_r;
    end
  end

  // Active field copy and the gains built from it
  assign ctrlSel  = fSync2_r ? oddCtrl_r : evenCtrl_r;
  assign ycMode   = ctrlSel[`VGFC_COMP_BIT];
  assign notchOn  = !ctrlSel[`VGFC_NOTCH_BIT] && !ycMode;
  assign decimOn  = !ctrlSel[`VGFC_DECIM_BIT];
  assign lumaGain = {ctrlSel[`VGFC_LGAIN_BIT], lumaLow_r};
  assign uGain    = {ctrlSel[`VGFC_UGAIN_BIT], uLow_r};
  assign vGain    = {ctrlSel[`VGFC_VGAIN_BIT], vLow_r};
  assign lineFall = hSync3_r && !hSync2_r;

  // Pixel position from the falling edge of the line reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pixCount_r <= 10'h000;
    else if (ce)
    begin
      if (lineFall)
        pixCount_r <= 10'h000;
      else if (vSync2_r && pixCount_r != 10'h3FF)
        pixCount_r <= pixCount_r + 10'h001;
    end
  end

  // Sample history; the chroma digitiser is ignored in composite mode
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      yD0_r     <= 8'h00;
      yD1_r     <= 8'h00;
      yD2_r     <= 8'h00;
      cD0_r     <= `VGFC_CHROMA_MID;
      cD1_r     <= `VGFC_CHROMA_MID;
      validB_r  <= 1'b0;
      phaseB_r  <= 1'b0;
      activeB_r <= 1'b0;
    end
    else if (ce)
    begin
      validB_r <= vSync2_r && !lineFall;
      if (vSync2_r && !lineFall)
      begin
        yD0_r     <= ySync2_r;
        yD1_r     <= yD0_r;
        yD2_r     <= yD1_r;
        phaseB_r  <= pixCount_r[0] ^ ctrlSel[`VGFC_ORDER_BIT];
        activeB_r <= pixCount_r >= horizontal_delay_r;
        if (ycMode)
        begin
          cD0_r <= cSync2_r;
          cD1_r <= cD0_r;
        end
      end
    end
  end

  // Composite chroma is the part the notch removes: (2*x1 - x0 - x2)/4
  assign bandPass = {2'b00, yD1_r, 1'b0} - {3'b000, yD0_r} - {3'b000, yD2_r};

  // Notch stage; a zero at a quarter of the sample rate traps the subcarrier
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lumaN_r   <= 8'h00;
      chromaC_r <= 10'sh000;
      validC_r  <= 1'b0;
      phaseC_r  <= 1'b0;
      activeC_r <= 1'b0;
    end
    else if (ce)
    begin
      validC_r  <= validB_r;
      phaseC_r  <= phaseB_r;
      activeC_r <= activeB_r;
      lumaN_r   <= notchOn ? avg2(yD0_r, yD2_r) : yD1_r;
      if (ycMode)
        chromaC_r <= {{2{~cD1_r[7]}}, cD1_r ^ `VGFC_CHROMA_MID};
      else
        chromaC_r <= {bandPass[10], bandPass[10:2]};
    end
  end

  // Decimation stage: 1-2-1 low pass on the notched luma
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lumaN1_r  <= 8'h00;
      lumaN2_r  <= 8'h00;
      lumaD_r   <= 8'h00;
      chromaD_r <= 10'sh000;
      validD_r  <= 1'b0;
      phaseD_r  <= 1'b0;
      activeD_r <= 1'b0;
    end
    else if (ce)
    begin
      validD_r  <= validC_r;
      phaseD_r  <= phaseC_r;
      activeD_r <= activeC_r;
      chromaD_r <= chromaC_r;
      if (validC_r)
      begin
        lumaN1_r <= lumaN_r;
        lumaN2_r <= lumaN1_r;
      end
      lumaD_r <= decimOn ? avg2(avg2(lumaN_r, lumaN2_r), lumaN1_r) : lumaN_r;
    end
  end

  // Gain and clip for luma, U and V
  vgfc_gain_clip #(.UNITY(`VGFC_LUMA_UNITY), .SIGNED_OUT(1'b0)) lumaGainClip
  (
    .sample (signed'({2'b00, lumaD_r})),
    .gain   (lumaGain),
    .result (lumaScaled)
  );

  vgfc_gain_clip #(.UNITY(`VGFC_U_UNITY), .SIGNED_OUT(1'b1)) uGainClip
  (
    .sample (chromaD_r),
    .gain   (uGain),
    .result (uScaled)
  );

  vgfc_gain_clip #(.UNITY(`VGFC_V_UNITY), .SIGNED_OUT(1'b1)) vGainClip
  (
    .sample (chromaD_r),
    .gain   (vGain),
    .result (vScaled)
  );

  // Output registers; Cb pixels take the U gain, Cr pixels the V gain
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lumaOut    <= 8'h00;
      chromaOut  <= 8'h00;
      chromaIsCr <= 1'b0;
      outValid   <= 1'b0;
      outActive  <= 1'b0;
    end
    else if (ce)
    begin
      lumaOut    <= lumaScaled;
      chromaOut  <= phaseD_r ? vScaled : uScaled;
      chromaIsCr <= phaseD_r;
      outValid   <= validD_r;
      outActive  <= activeD_r && validD_r;
    end
  end

  // Helper for the clipping check
  assign lumaProdChk = 18'(lumaD_r) * 18'(lumaGain); // Widened first so the product keeps every bit

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_write(logic [7:0] off);
    ce && apbState_r == VGFC_DONE && psel && penable && pwrite && paddr == off;
  endsequence

  sequence s_bypassStep;
    ce && validB_r && !notchOn;
  endsequence

  a_ctrl_reset: assert property (
    $past(!rst_b) |-> evenCtrl_r == `VGFC_CTRL_RST && oddCtrl_r == `VGFC_CTRL_RST &&
                      lumaLow_r == `VGFC_LUMA_LOW_RST && uLow_r == `VGFC_U_LOW_RST &&
                      vLow_r == `VGFC_V_LOW_RST)
    else $error("control registers not at reset values");

  a_odd_write: assert property (
    s_write(`VGFC_ODD_CTRL_OFF) |=> oddCtrl_r == $past(pwdata[7:0]) &&
                                    $stable(evenCtrl_r))
    else $error("odd field control write not applied");

  a_notch_bypass: assert property (
    s_bypassStep |=> lumaN_r == $past(yD1_r))
    else $error("luma notch not bypassed");

  a_notch_insert: assert property (
    ce && validB_r && notchOn |=> lumaN_r == avg2($past(yD0_r), $past(yD2_r)))
    else $error("luma notch not applied");

  a_cadc_gated: assert property (
    ce && !ycMode |=> $stable(cD0_r) && $stable(cD1_r))
    else $error("chroma digitiser used in composite mode");

  a_decim_off: assert property (
    ce && !decimOn |=> lumaD_r == $past(lumaN_r))
    else $error("luma decimation not disabled");

  a_first_cb: assert property (
    ce && vSync2_r && !lineFall && pixCount_r == horizontal_delay_r &&
    horizontal_delay_r[0] == ctrlSel[`VGFC_ORDER_BIT] |=> !phaseB_r ##3 !chromaIsCr)
    else $error("first active pixel is not Cb");

  a_luma_unity: assert property (
    ce && lumaGain == `VGFC_LUMA_UNITY |=> lumaOut == $past(lumaD_r))
    else $error("unity luma gain altered sample");

  a_luma_clip: assert property (
    ce && lumaProdChk >= 18'h0_D728 |=> lumaOut == 8'hFF)
    else $error("luma product did not clip");

  a_u_unity: assert property (
    ce && !phaseD_r && uGain == `VGFC_U_UNITY |=> chromaOut == $past(chromaD_r[7:0]))
    else $error("unity U gain altered sample");

endmodule : vgfc_top

`default_nettype wire
